/* File: hw/pim_mode_selector.sv */
// Purpose: choose pi or p-only speed loop control from request pin and mode switch
// Assumes: one 50 MHz clock, sync active-high reset, signed quantities sampled each cycle
// Notes: loop arithmetic lives elsewhere; this block outputs the mode decision and the speed reference input gain
// Function
// R1: a speed reference input gain of 150 to 3000, default 600, takes effect at once.
// R2: with the request pin high the speed loop runs pi control.
// R3: with the request pin low the speed loop runs p-only control.
// R4: the request is honoured only in speed control or position control methods.
// R5: in torque control the request is ignored and p-only is never chosen.
// R6: combined methods need the request routed to an input terminal by the integrator; here the request is ignored in any method but speed or position.
// R7: select 0 switches to p-only when torque reference exceeds a 0 to 800 percent level.
// R8: the torque level defaults to 200 percent and torque selection is the default.
// R9: select 1 switches when speed reference exceeds a 0 to 10000 level, default 0.
// R10: select 2 uses an acceleration level of 0 to 30000, default 0.
// R11: select 3 uses a position error level of 0 to 10000, default 0.
// R12: select 4 turns automatic switching off, leaving only the request.
// R13: under acceleration select, p-only applies while reference acceleration exceeds its level.
// R14: position error switching acts only in position control.
// R15: p-only applies when the request or the automatic condition holds, else pi.
// R16: comparisons use magnitudes and are redone every cycle.
//
// Our own choices: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ps
`default_nettype none

module pim_mode_selector
    import pim_pkg::*;
(
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic propCtrlRequestN,
    input wire logic signed [pim_pkg::ParW-1:0] torqueRef,
    input wire logic signed [pim_pkg::ParW-1:0] speedRef,
    input wire logic signed [pim_pkg::ParW-1:0] speedRefAccel,
    input wire logic signed [pim_pkg::ParW-1:0] positionError,
    input wire logic [pim_pkg::AddrW-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [pim_pkg::DataW-1:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [pim_pkg::AddrW-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [pim_pkg::DataW-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic propOnly,
    output logic [pim_pkg::ParW-1:0] speedRefInputGain
);
    import pim_pkg::*;

    // magnitude of a signed quantity; most negative saturates
    function automatic logic [ParW-1:0] magOf(input logic signed [ParW-1:0] v);
        logic [ParW-1:0] m;
        m = v[ParW-1] ? ParW'(-v) : ParW'(v);
        if (m[ParW-1] && v[ParW-1])
        begin
            m = {1'b0, {(ParW-1){1'b1}}};
        end
        return m;
    endfunction : magOf

    // clamp a written value into its legal range
    function automatic logic [ParW-1:0] clampTo(input logic [ParW-1:0] v,
                                                 input logic [ParW-1:0] lo,
                                                 input logic [ParW-1:0] hi);
        logic [ParW-1:0] r;
        r = v;
        if (v < lo)
        begin
            r = lo;
        end
        else if (v > hi)
        begin
            r = hi;
        end
        return r;
    endfunction : clampTo

    ////////////////////////////////////////////////////////////////////////////
    // request pin synchroniser: three flops, change counts when 2nd and 3rd agree

    logic reqS1_q, reqS2_q, reqS3_q, reqN_q;
    logic reqS1_d, reqS2_d, reqS3_d, reqN_d;

    // next values of the synchroniser and the filtered level
    always_comb
    begin
        reqS1_d = propCtrlRequestN;
        reqS2_d = reqS1_q;
        reqS3_d = reqS2_q;
        reqN_d = reqN_q;
        if (reqS2_q == reqS3_q)
        begin
            reqN_d = reqS3_q;
        end
    end

    // pin idles high so reset to inactive
    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            reqS1_q <= 1'b1;
            reqS2_q <= 1'b1;
            reqS3_q <= 1'b1;
            reqN_q <= 1'b1;
        end
        else
        begin
            reqS1_q <= reqS1_d;
            reqS2_q <= reqS2_d;
            reqS3_q <= reqS3_d;
            reqN_q <= reqN_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // axi4-lite slave and parameter registers

    logic [ParW-1:0] gain_q, method_q, swSel_q, torqLvl_q, spdLvl_q, accLvl_q, posLvl_q;
    logic [ParW-1:0] gain_d, method_d, swSel_d, torqLvl_d, spdLvl_d, accLvl_d, posLvl_d;
    logic awHeld_q, wHeld_q, bValid_q, rValid_q;
    logic awHeld_d, wHeld_d, bValid_d, rValid_d;
    logic [AddrW-1:0] awAddr_q, awAddr_d;
    logic [DataW-1:0] wData_q, wData_d, rData_q, rData_d;
    logic [3:0] wStrb_q, wStrb_d;
    logic [1:0] bResp_q, bResp_d, rResp_q, rResp_d;
    logic prop_q, prop_d, auto_q, auto_d, reqAct_q, reqAct_d;
    logic awRdy_q, awRdy_d, wRdy_q, wRdy_d, arRdy_q, arRdy_d;

    // ready flags registered from next state so the ports come from flops
    assign awRdy_d = !awHeld_d && !bValid_d;
    assign wRdy_d = !wHeld_d && !bValid_d;
    assign arRdy_d = !rValid_d;

    // write path: address and data taken in either order, one write in flight
    always_comb
    begin
        logic [ParW-1:0] wv;
        wv = '0;
        awHeld_d = awHeld_q;
        wHeld_d = wHeld_q;
        awAddr_d = awAddr_q;
        wData_d = wData_q;
        wStrb_d = wStrb_q;
        bValid_d = bValid_q;
        bResp_d = bResp_q;
        gain_d = gain_q;
        method_d = method_q;
        swSel_d = swSel_q;
        torqLvl_d = torqLvl_q;
        spdLvl_d = spdLvl_q;
        accLvl_d = accLvl_q;
        posLvl_d = posLvl_q;
        if (s_axi_awvalid && !awHeld_q && !bValid_q)
        begin
            awHeld_d = 1'b1;
            awAddr_d = s_axi_awaddr;
        end
        if (s_axi_wvalid && !wHeld_q && !bValid_q)
        begin
            wHeld_d = 1'b1;
            wData_d = s_axi_wdata;
            wStrb_d = s_axi_wstrb;
        end
        if (bValid_q && s_axi_bready)
        begin
            bValid_d = 1'b0;
        end
        if (awHeld_q && wHeld_q)
        begin
            awHeld_d = 1'b0;
            wHeld_d = 1'b0;
            bValid_d = 1'b1;
            bResp_d = RespOkay;
            wv = wData_q[ParW-1:0];
            // low two byte lanes hold each 16-bit setting
            if (!wStrb_q[0])
            begin
                wv[7:0] = 8'h00;
            end
            if (!wStrb_q[1])
            begin
                wv[15:8] = 8'h00;
            end
            // R1: gain range, immediate effect
            if (awAddr_q == OffSpeedGain)
            begin
                gain_d = clampTo(wStrb_q[1:0] == 2'b11 ? wv : {wStrb_q[1] ? wv[15:8] : gain_q[15:8],
                                 wStrb_q[0] ? wv[7:0] : gain_q[7:0]}, GainMin, GainMax);
            end
            else if (awAddr_q == OffCtrlMethod)
            begin
                method_d = {wStrb_q[1] ? wv[15:8] : method_q[15:8], wStrb_q[0] ? wv[7:0] : method_q[7:0]};
            end
            else if (awAddr_q == OffSwSelect)
            begin
                swSel_d = {wStrb_q[1] ? wv[15:8] : swSel_q[15:8], wStrb_q[0] ? wv[7:0] : swSel_q[7:0]};
            end
            // R7: torque level range
            else if (awAddr_q == OffTorqLevel)
            begin
                torqLvl_d = clampTo({wStrb_q[1] ? wv[15:8] : torqLvl_q[15:8],
                                    wStrb_q[0] ? wv[7:0] : torqLvl_q[7:0]}, '0, TorqMax);
            end
            // R9: speed level range
            else if (awAddr_q == OffSpdLevel)
            begin
                spdLvl_d = clampTo({wStrb_q[1] ? wv[15:8] : spdLvl_q[15:8],
                                   wStrb_q[0] ? wv[7:0] : spdLvl_q[7:0]}, '0, SpdMax);
            end
            // R10: acceleration level range
            else if (awAddr_q == OffAccLevel)
            begin
                accLvl_d = clampTo({wStrb_q[1] ? wv[15:8] : accLvl_q[15:8],
                                   wStrb_q[0] ? wv[7:0] : accLvl_q[7:0]}, '0, AccMax);
            end
            // R11: position error level range
            else if (awAddr_q == OffPosLevel)
            begin
                posLvl_d = clampTo({wStrb_q[1] ? wv[15:8] : posLvl_q[15:8],
                                   wStrb_q[0] ? wv[7:0] : posLvl_q[7:0]}, '0, PosMax);
            end
            else if (awAddr_q != OffStatus)
            begin
                bResp_d = RespSlvErr;
            end
        end
    end

    // read path: one read in flight, answer one cycle after address taken
    always_comb
    begin
        rValid_d = rValid_q;
        rData_d = rData_q;
        rResp_d = rResp_q;
        if (rValid_q && s_axi_rready)
        begin
            rValid_d = 1'b0;
        end
        if (s_axi_arvalid && !rValid_q)
        begin
            rValid_d = 1'b1;
            rResp_d = RespOkay;
            rData_d = '0;
            if (s_axi_araddr == OffSpeedGain)
            begin
                rData_d[ParW-1:0] = gain_q;
            end
            else if (s_axi_araddr == OffCtrlMethod)
            begin
                rData_d[ParW-1:0] = method_q;
            end
            else if (s_axi_araddr == OffSwSelect)
            begin
                rData_d[ParW-1:0] = swSel_q;
            end
            else if (s_axi_araddr == OffTorqLevel)
            begin
                rData_d[ParW-1:0] = torqLvl_q;
            end
            else if (s_axi_araddr == OffSpdLevel)
            begin
                rData_d[ParW-1:0] = spdLvl_q;
            end
            else if (s_axi_araddr == OffAccLevel)
            begin
                rData_d[ParW-1:0] = accLvl_q;
            end
            else if (s_axi_araddr == OffPosLevel)
            begin
                rData_d[ParW-1:0] = posLvl_q;
            end
            else if (s_axi_araddr == OffStatus)
            begin
                rData_d[StPropBit] = prop_q;
                rData_d[StReqBit] = reqAct_q;
                rData_d[StAutoBit] = auto_q;
            end
            else
            begin
                rResp_d = RespSlvErr;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // mode decision, redone every cycle

    always_comb
    begin
        logic [DigitW-1:0] meth;
        logic [DigitW-1:0] sel;
        meth = method_q[MethodLsb +: DigitW];
        sel = swSel_q[SelLsb +: DigitW];
        // R4: request honoured in speed or position control only
        // R5: torque control never goes p-only
        // R6: combined methods (other method codes) ignore the request, whatever the routing
        reqAct_d = !reqN_q && (meth == MethSpeed || meth == MethPos);
        // R16: magnitude compares, every cycle
        case (sel)
            // R7: torque reference over level
            SelTorque: auto_d = magOf(torqueRef) > torqLvl_q;
            // R9: speed reference over level
            SelSpeed: auto_d = magOf(speedRef) > spdLvl_q;
            // R13: reference acceleration over level
            SelAccel: auto_d = magOf(speedRefAccel) > accLvl_q;
            // R14: position error only in position control
            SelPosErr: auto_d = (meth == MethPos) && (magOf(positionError) > posLvl_q);
            // R12: no automatic switching
            default: auto_d = 1'b0;
        endcase
        if (meth == MethTorque)
        begin
            auto_d = 1'b0;
        end
        // R2: R3: R15: p-only when request or auto, else pi
        prop_d = reqAct_d || auto_d;
    end

    // every register of the block except the request synchroniser; parameters hold factory values on reset
    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            // R1: gain default
            gain_q <= RstSpeedGain;
            method_q <= RstCtrlMethod;
            // R8: torque select and 200 percent default
            swSel_q <= RstSwSelect;
            torqLvl_q <= RstTorqLevel;
            spdLvl_q <= RstSpdLevel;
            accLvl_q <= RstAccLevel;
            posLvl_q <= RstPosLevel;
            awHeld_q <= 1'b0;
            wHeld_q <= 1'b0;
            awAddr_q <= '0;
            wData_q <= '0;
            wStrb_q <= '0;
            bValid_q <= 1'b0;
            bResp_q <= RespOkay;
            rValid_q <= 1'b0;
            rData_q <= '0;
            rResp_q <= RespOkay;
            awRdy_q <= 1'b1;
            wRdy_q <= 1'b1;
            arRdy_q <= 1'b1;
            prop_q <= 1'b0;
            auto_q <= 1'b0;
            reqAct_q <= 1'b0;
        end
        else
        begin
            gain_q <= gain_d;
            method_q <= method_d;
            swSel_q <= swSel_d;
            torqLvl_q <= torqLvl_d;
            spdLvl_q <= spdLvl_d;
            accLvl_q <= accLvl_d;
            posLvl_q <= posLvl_d;
            awHeld_q <= awHeld_d;
            wHeld_q <= wHeld_d;
            awAddr_q <= awAddr_d;
            wData_q <= wData_d;
            wStrb_q <= wStrb_d;
            bValid_q <= bValid_d;
            bResp_q <= bResp_d;
            rValid_q <= rValid_d;
            rData_q <= rData_d;
            rResp_q <= rResp_d;
            awRdy_q <= awRdy_d;
            wRdy_q <= wRdy_d;
            arRdy_q <= arRdy_d;
            prop_q <= prop_d;
            auto_q <= auto_d;
            reqAct_q <= reqAct_d;
        end
    end

    // outputs straight from flops; ready held low while a channel is captured
    assign s_axi_awready = awRdy_q;
    assign s_axi_wready = wRdy_q;
    assign s_axi_bvalid = bValid_q;
    assign s_axi_bresp = bResp_q;
    assign s_axi_arready = arRdy_q;
    assign s_axi_rvalid = rValid_q;
    assign s_axi_rdata = rData_q;
    assign s_axi_rresp = rResp_q;
    assign propOnly = prop_q;
    assign speedRefInputGain = gain_q;

endmodule : pim_mode_selector

`default_nettype wire

/* File: hw/pim_pkg.sv */
// Purpose: constants for the p/pi mode selector
// Assumes: axi4-lite register access, 32-bit data, 50 MHz clock
// Notes: register offsets are byte addresses
package pim_pkg;

    localparam int unsigned DataW = 32;
    localparam int unsigned AddrW = 8;
    localparam int unsigned ParW = 16;

    // register byte offsets
    localparam logic [AddrW-1:0] OffSpeedGain = 8'h00;
    localparam logic [AddrW-1:0] OffCtrlMethod = 8'h04;
    localparam logic [AddrW-1:0] OffSwSelect = 8'h08;
    localparam logic [AddrW-1:0] OffTorqLevel = 8'h0c;
    localparam logic [AddrW-1:0] OffSpdLevel = 8'h10;
    localparam logic [AddrW-1:0] OffAccLevel = 8'h14;
    localparam logic [AddrW-1:0] OffPosLevel = 8'h18;
    localparam logic [AddrW-1:0] OffStatus = 8'h1c;

    // reset values
    localparam logic [ParW-1:0] RstSpeedGain = 16'h0258;
    localparam logic [ParW-1:0] RstCtrlMethod = 16'h0000;
    localparam logic [ParW-1:0] RstSwSelect = 16'h0000;
    localparam logic [ParW-1:0] RstTorqLevel = 16'h00c8;
    localparam logic [ParW-1:0] RstSpdLevel = 16'h0000;
    localparam logic [ParW-1:0] RstAccLevel = 16'h0000;
    localparam logic [ParW-1:0] RstPosLevel = 16'h0000;

    // legal setting ranges; writes are clamped into them
    localparam logic [ParW-1:0] GainMin = 16'h0096;
    localparam logic [ParW-1:0] GainMax = 16'h0bb8;
    localparam logic [ParW-1:0] TorqMax = 16'h0320;
    localparam logic [ParW-1:0] SpdMax = 16'h2710;
    localparam logic [ParW-1:0] AccMax = 16'h7530;
    localparam logic [ParW-1:0] PosMax = 16'h2710;

    // control method field (digit 1) and switch select field (digit 0)
    localparam int unsigned MethodLsb = 4;
    localparam int unsigned DigitW = 4;
    localparam int unsigned SelLsb = 0;

    localparam logic [DigitW-1:0] MethSpeed = 4'h0;
    localparam logic [DigitW-1:0] MethPos = 4'h1;
    localparam logic [DigitW-1:0] MethTorque = 4'h2;

    localparam logic [DigitW-1:0] SelTorque = 4'h0;
    localparam logic [DigitW-1:0] SelSpeed = 4'h1;
    localparam logic [DigitW-1:0] SelAccel = 4'h2;
    localparam logic [DigitW-1:0] SelPosErr = 4'h3;

    // status register bits
    localparam int unsigned StPropBit = 0;
    localparam int unsigned StReqBit = 1;
    localparam int unsigned StAutoBit = 2;

    localparam logic [1:0] RespOkay = 2'b00;
    localparam logic [1:0] RespSlvErr = 2'b10;

endpackage : pim_pkg

/* File: tb/pim_mode_selector_asserts.sv */
// Purpose: port-level checks for the p/pi mode selector
// Assumes: one clock domain, srst synchronous active high
// Notes: bound from the bench top file
`timescale 1ns/1ps
`default_nettype none
module pim_mode_selector_asserts
    import pim_pkg::*;
(
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic propCtrlRequestN,
    input wire logic signed [pim_pkg::ParW-1:0] torqueRef,
    input wire logic signed [pim_pkg::ParW-1:0] speedRef,
    input wire logic signed [pim_pkg::ParW-1:0] speedRefAccel,
    input wire logic signed [pim_pkg::ParW-1:0] positionError,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [pim_pkg::DataW-1:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic propOnly,
    input wire logic [pim_pkg::ParW-1:0] speedRefInputGain
);
////////////////////////////////////////////////////////////////////////////////
logic [64:0] snapNow;
logic [64:0] snapQ;
logic [3:0] quietD;
logic [3:0] quietQ;
assign snapNow = {propCtrlRequestN, torqueRef, speedRef, speedRefAccel, positionError};
// quiet count; a write restarts it since settings land two edges later
always_comb
begin
    quietD = (quietQ == 4'hf) ? quietQ : quietQ + 4'h1;
    if (srst || snapNow != snapQ || (s_axi_awvalid && s_axi_awready))
        quietD = 4'h0;
end
always_ff @(posedge clk_sys)
begin
    snapQ <= snapNow;
    quietQ <= quietD;
end
////////////////////////////////////////////////////////////////////////////////
default clocking cb @(posedge clk_sys); endclocking
default disable iff (srst);
respHold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
readHold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
writeAnswer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |=> ##1 s_axi_bvalid) else $error("write response late");
readAnswer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read response late");
gainRange_a: assert property (speedRefInputGain >= GainMin && speedRefInputGain <= GainMax)
    else $error("gain outside legal range");
resetState_a: assert property ($fell(srst) |-> !propOnly && speedRefInputGain == RstSpeedGain
    && !s_axi_bvalid && !s_axi_rvalid) else $error("bad state after reset");
oneWrite_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while response pending");
modeSettled_a: assert property (quietQ >= 4'h6 |-> $stable(propOnly))
    else $error("mode changed with quiet inputs");
cover property (s_axi_bvalid && s_axi_bready);
cover property (s_axi_rvalid && s_axi_rready);
cover property ($rose(propOnly));
cover property ($fell(propOnly));
endmodule : pim_mode_selector_asserts
`default_nettype wire

/* File: tb/pim_host_model.sv */
// Purpose: host controller stand-in driving request pin and references
// Assumes: bench sets targets; model launches them at the next rising edge
// Notes: one value feeds all four quantities to keep the bench table short
`timescale 1ns/1ps
`default_nettype none
module pim_host_model
(
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic reqNSet,
    input wire logic [pim_pkg::ParW-1:0] valSet,
    output logic propCtrlRequestN,
    output logic signed [pim_pkg::ParW-1:0] torqueRef,
    output logic signed [pim_pkg::ParW-1:0] speedRef,
    output logic signed [pim_pkg::ParW-1:0] speedRefAccel,
    output logic signed [pim_pkg::ParW-1:0] positionError
);
// request always routed
// request pin rests high (inactive) while the host is in reset
always_ff @(posedge clk_sys)
begin
    propCtrlRequestN <= srst ? 1'b1 : reqNSet;
    torqueRef <= valSet;
    speedRef <= valSet;
    speedRefAccel <= valSet;
    positionError <= valSet;
end
endmodule : pim_host_model
`default_nettype wire

/* File: tb/pim_mode_selector_bench.sv */
// Purpose: self-checking bench for the p/pi mode selector
// Assumes: 50 MHz clock, srst held two cycles, axi4-lite master tasks
// Notes: reset values first, then table rows, then clamping and bus error cases
`timescale 1ns/1ps
`default_nettype none
module pim_mode_selector_bench;
import pim_pkg::*;
typedef struct packed
{
    logic [3:0] meth;
    logic [3:0] sel;
    logic reqN;
    logic [15:0] val;
    logic exp;
} pim_row_t;
localparam int SettleCyc = 7;
logic clk_sys = 1'b0;
logic srst = 1'b1;
logic reqNSet = 1'b1;
logic [ParW-1:0] valSet = 16'h0000;
logic propCtrlRequestN, propOnly;
logic signed [ParW-1:0] torqueRef, speedRef, speedRefAccel, positionError;
logic [AddrW-1:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
logic [DataW-1:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
logic [3:0] s_axi_wstrb = 4'hf;
logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
logic [1:0] s_axi_bresp, s_axi_rresp, rs;
logic [ParW-1:0] speedRefInputGain;
int badCount = 0;
int cmpCount = 0;
logic [15:0] rstExp [7] = '{RstSpeedGain, RstCtrlMethod, RstSwSelect, RstTorqLevel,
    RstSpdLevel, RstAccLevel, RstPosLevel};
// levels in use: torque 100, speed 500, accel 1000, position error 50
pim_row_t rows [15] = '{'{4'h0, 4'h4, 1'b1, 16'h0000, 1'b0}, '{4'h0, 4'h4, 1'b0, 16'h0000, 1'b1},
    '{4'h1, 4'h4, 1'b0, 16'h0000, 1'b1}, '{4'h2, 4'h4, 1'b0, 16'h0000, 1'b0},
    '{4'h3, 4'h4, 1'b0, 16'h0000, 1'b0}, '{4'h0, 4'h0, 1'b1, 16'h0065, 1'b1},
    '{4'h0, 4'h0, 1'b1, 16'h0064, 1'b0}, '{4'h0, 4'h0, 1'b1, 16'hff9b, 1'b1},
    '{4'h0, 4'h1, 1'b1, 16'h01f5, 1'b1}, '{4'h0, 4'h1, 1'b1, 16'h0065, 1'b0},
    '{4'h0, 4'h2, 1'b1, 16'h03e9, 1'b1}, '{4'h1, 4'h3, 1'b1, 16'h0033, 1'b1},
    '{4'h0, 4'h3, 1'b1, 16'h0033, 1'b0}, '{4'h2, 4'h0, 1'b1, 16'h0384, 1'b0},
    '{4'h0, 4'h4, 1'b1, 16'h0384, 1'b0}};
always #10 clk_sys = ~clk_sys;
pim_mode_selector dut_u (.clk_sys, .srst, .propCtrlRequestN, .torqueRef, .speedRef,
    .speedRefAccel, .positionError, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .propOnly, .speedRefInputGain);
pim_host_model host_u (.clk_sys, .srst, .reqNSet, .valSet, .propCtrlRequestN, .torqueRef,
    .speedRef, .speedRefAccel, .positionError);
////////////////////////////////////////////////////////////////////////////////
task automatic finishTest;
    $display("compares %0d mismatches %0d", cmpCount, badCount);
    if (badCount == 0 && cmpCount > 0)
        $display("All checks passed");
    else
        $display("Checks failed");
    $finish;
endtask : finishTest
task automatic checkVal(input logic [31:0] seen, input logic [31:0] exp, input string what);
    cmpCount++;
    if (seen !== exp)
    begin
        badCount++;
        $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
endtask : checkVal
task automatic timeOut(input int n);
    if (n >= 20)
    begin
        badCount++;
        $display("[FAIL] bus answer expected within 20 cycles seen none");
        finishTest();
    end
endtask : timeOut
// address and data offered together, each dropped once taken
task automatic axiWrite(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge clk_sys);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    r = 2'b11;
    for (n = 0; n < 20; n++)
    begin
        @(posedge clk_sys);
        if (s_axi_awvalid && s_axi_awready)
            s_axi_awvalid <= 1'b0;
        if (s_axi_wvalid && s_axi_wready)
            s_axi_wvalid <= 1'b0;
        if (s_axi_bvalid)
        begin
            r = s_axi_bresp;
            s_axi_bready <= 1'b0;
            break;
        end
    end
    timeOut(n);
endtask : axiWrite
task automatic axiRead(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge clk_sys);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    r = 2'b11;
    d = 32'h0;
    for (n = 0; n < 20; n++)
    begin
        @(posedge clk_sys);
        if (s_axi_arvalid && s_axi_arready)
            s_axi_arvalid <= 1'b0;
        if (s_axi_rvalid)
        begin
            d = s_axi_rdata;
            r = s_axi_rresp;
            s_axi_rready <= 1'b0;
            break;
        end
    end
    timeOut(n);
endtask : axiRead
////////////////////////////////////////////////////////////////////////////////
// main sequence: reset, table rows, then clamping and bus errors
initial
begin
    repeat (2) @(posedge clk_sys);
    srst <= 1'b0;
    for (int i = 0; i < 7; i++)
    begin
        axiRead(8'(i * 4), rd, rs);
        checkVal(rd, {16'h0000, rstExp[i]}, "reset value");
    end
    checkVal({16'h0000, speedRefInputGain}, 32'h0000_0258, "gain port");
    valSet <= 16'h00c9;
    repeat (SettleCyc) @(posedge clk_sys);
    checkVal({31'h0, propOnly}, 32'h1, "default torque switch");
    $display("test reset done");
    axiWrite(OffTorqLevel, 32'h0064, rs);
    axiWrite(OffSpdLevel, 32'h01f4, rs);
    axiWrite(OffAccLevel, 32'h03e8, rs);
    axiWrite(OffPosLevel, 32'h0032, rs);
    foreach (rows[i])
    begin
        axiWrite(OffCtrlMethod, {24'h0, rows[i].meth, 4'h0}, rs);
        axiWrite(OffSwSelect, {28'h0, rows[i].sel}, rs);
        reqNSet <= rows[i].reqN;
        valSet <= rows[i].val;
        repeat (SettleCyc) @(posedge clk_sys);
        checkVal({31'h0, propOnly}, {31'h0, rows[i].exp}, "mode row");
    end
    $display("test table done");
    axiWrite(OffSpeedGain, 32'h0064, rs);
    axiRead(OffSpeedGain, rd, rs);
    checkVal(rd, 32'h0096, "gain low clamp");
    axiWrite(OffSpeedGain, 32'h0fa0, rs);
    axiRead(OffSpeedGain, rd, rs);
    checkVal(rd, 32'h0bb8, "gain high clamp");
    axiWrite(OffSpeedGain, 32'h04d2, rs);
    repeat (2) @(posedge clk_sys);
    checkVal({16'h0000, speedRefInputGain}, 32'h04d2, "gain immediate");
    $display("test gain done");
    axiWrite(8'h20, 32'h1234, rs);
    checkVal({30'h0, rs}, {30'h0, RespSlvErr}, "unmapped write resp");
    axiRead(8'h20, rd, rs);
    checkVal({30'h0, rs}, {30'h0, RespSlvErr}, "unmapped read resp");
    checkVal(rd, 32'h0, "unmapped read data");
    axiWrite(OffStatus, 32'h0007, rs);
    checkVal({30'h0, rs}, {30'h0, RespOkay}, "status write resp");
    $display("test bus errors done");
    finishTest();
end
endmodule : pim_mode_selector_bench
bind pim_mode_selector pim_mode_selector_asserts chk_u (.clk_sys, .srst, .propCtrlRequestN,
    .torqueRef, .speedRef, .speedRefAccel, .positionError, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .propOnly,
    .speedRefInputGain);
`default_nettype wire
